// ### logic/ext_irq_defines.svh
// Register indices, field positions, reset values and filter counts of the interrupt front end.
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map: printed indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define EXT_GATE_IDX 12'h0f77
`define EXT_CFG1_IDX 12'h0fd8
`define EXT_CFG2_IDX 12'h0fd9
`define EXT_ADDR_W 14

// ----------------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------------
`define EXT_CFG_LVL_BIT 4
`define EXT_CFG_TRIG_HI 3
`define EXT_CFG_TRIG_LO 2
`define EXT_CFG_RATE_HI 1
`define EXT_CFG_RATE_LO 0
`define EXT_GATE_RESET 6'h00
`define EXT_CFG_RESET 4'h0

// ----------------------------------------------------------------------------
// Encodings and timing counts.
// ----------------------------------------------------------------------------
`define EXT_TRIG_RISE 2'b00
`define EXT_TRIG_FALL 2'b01
`define EXT_TRIG_BOTH 2'b10
`define EXT_RATE_DIV1 2'b00
`define EXT_RATE_DIV4 2'b01
`define EXT_RATE_DIV8 2'b10
`define EXT_RATE_DIV16 2'b11
`define EXT_LF_LAST 2'h3
`define EXT_STABLE_TICKS 2

`endif

// ### logic/ext_irq_pkg.sv
// Types shared by the interrupt front end modules.
package ext_irq_pkg;

    // Register selected by a bus address.
    typedef enum logic [1:0] {
        REG_NONE,
        REG_GATE,
        REG_CFG1,
        REG_CFG2
    } reg_sel_t;

    // State of the noise canceller.
    typedef struct packed {
        logic [1:0] runLen;
        logic out;
    } filt_state_t;

    // State of the trigger detector.
    typedef struct packed {
        logic prev;
        logic req;
        logic lvl;
    } det_state_t;

    // State of the top level: bus slave, registers and prescalers.
    typedef struct packed {
        logic [5:0] gate;
        logic [3:0] cfg1;
        logic [3:0] cfg2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [3:0] preScale;
        logic lfPrev;
        logic [1:0] lfCnt;
    } top_state_t;

endpackage

// ### logic/noise_canceller.sv
// Sampling noise canceller for one external interrupt pin.
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defines.svh"

module noise_canceller #(
    parameter int STABLE_TICKS = `EXT_STABLE_TICKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic tick,
    input wire logic din,
    output logic dout
);
    import ext_irq_pkg::*;

    filt_state_t q;
    filt_state_t d;

    // The output follows the pin only after enough consecutive ticks agree.
    // While ungated nothing moves, which stands in for the stopped clock.
    always_comb begin
        d = q;
        if (run && tick) begin
            if (din == q.out) begin
                d.runLen = 2'h0;
            end else if (q.runLen == 2'(STABLE_TICKS - 1)) begin
                d.out = din;
                d.runLen = 2'h0;
            end else begin
                d.runLen = q.runLen + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.out;

    // A change on the output is always a level the pin held on a tick.
    chk_filter_stable: assert property (@(posedge clk) disable iff (!resetn)
        (dout != $past(dout)) |-> ($past(tick) && $past(run) && $past(din) == dout))
        else $error("canceller output changed without a qualifying tick");

endmodule
`default_nettype wire

// ### logic/trigger_detect.sv
// Edge detector and captured-level flag for one filtered interrupt source.
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defines.svh"

module trigger_detect (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic filtered,
    input wire logic [1:0] trig,
    output logic reqPulse,
    output logic level
);
    import ext_irq_pkg::*;

    det_state_t q;
    det_state_t d;
    logic rise;
    logic fall;
    logic hit;

    // Only the canceller output is watched, never the raw pin.
    assign rise = filtered && !q.prev;
    assign fall = !filtered && q.prev;

    // Select the request condition; the reserved code never requests.
    always_comb begin
        unique case (trig)
            `EXT_TRIG_RISE: hit = rise;
            `EXT_TRIG_FALL: hit = fall;
            `EXT_TRIG_BOTH: hit = rise || fall;
            default: hit = 1'b0;
        endcase
    end

    // One-cycle request and level capture at the same edge.
    always_comb begin
        d = q;
        d.req = 1'b0;
        if (run) begin
            d.prev = filtered;
            if (hit) begin
                d.req = 1'b1;
                d.lvl = filtered;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign reqPulse = q.req;
    assign level = q.lvl;

endmodule
`default_nettype wire

// ### logic/ext_interrupt_filter_edge.sv
// External interrupt front end: clock gates, noise cancellers, trigger detectors, APB registers.
//
// How it works
// - Gate bit zero freezes source, ignores config writes
// - Gate register bits 7 and 6 read zero
// - Trigger code: rise, fall, both, reserved
// - Requests come from canceller output only
// - Fast modes: rate field picks divider
// - Slow modes: sample at quarter low clock
// - Level flag holds filtered level at request
// - Config bits 7 to 5 read zero
// - Level flag refreshed on every request
// - Sources 0,3,4,5 use fixed settings
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defines.svh"

module ext_interrupt_filter_edge #(
    parameter int STABLE_TICKS = `EXT_STABLE_TICKS,
    parameter logic [23:0] FIXED_CFG = 24'h40_0004
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`EXT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [5:0] extIrqPin,
    input wire logic slowMode,
    input wire logic lowFreqClk,
    output logic [5:0] irqRequest
);
    import ext_irq_pkg::*;

    // ------------------------------------------------------------------------
    // Shared decoding.
    // ------------------------------------------------------------------------

    // Map a byte address to a register; misaligned words are unmapped.
    function automatic reg_sel_t decodeReg(input logic [`EXT_ADDR_W-1:0] a);
        if (a == {`EXT_GATE_IDX, 2'b00}) begin
            return REG_GATE;
        end else if (a == {`EXT_CFG1_IDX, 2'b00}) begin
            return REG_CFG1;
        end else if (a == {`EXT_CFG2_IDX, 2'b00}) begin
            return REG_CFG2;
        end
        return REG_NONE;
    endfunction

    // Sampling tick for one source from the shared prescalers.
    function automatic logic rateTick(input logic [1:0] rate, input logic slow,
                                      input logic [3:0] pre, input logic lfTick);
        logic t;
        t = 1'b0;
        if (slow) begin
            t = lfTick;
        end else begin
            unique case (rate)
                `EXT_RATE_DIV1: t = 1'b1;
                `EXT_RATE_DIV4: t = (pre[1:0] == 2'h3);
                `EXT_RATE_DIV8: t = (pre[2:0] == 3'h7);
                `EXT_RATE_DIV16: t = (pre == 4'hf);
            endcase
        end
        return t;
    endfunction

    top_state_t q;
    top_state_t d;
    reg_sel_t sel;
    logic access;
    logic wrAccept;
    logic lfTick;
    logic [3:0] srcCfg [6];
    logic [5:0] tick;
    logic [5:0] filtered;
    logic [5:0] srcLevel;

    assign sel = decodeReg(paddr);
    assign access = psel && penable;
    assign wrAccept = access && q.pready && pwrite && !q.pslverr;
    assign lfTick = lowFreqClk && !q.lfPrev && (q.lfCnt == `EXT_LF_LAST);

    // ------------------------------------------------------------------------
    // Per-source configuration: only sources 1 and 2 are programmable here.
    // ------------------------------------------------------------------------

    // Out-of-range sources take their fixed nibble from FIXED_CFG.
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            srcCfg[k] = FIXED_CFG[4*k +: 4];
        end
        srcCfg[1] = q.cfg1;
        srcCfg[2] = q.cfg2;
    end

    // ------------------------------------------------------------------------
    // Source channels.
    // ------------------------------------------------------------------------
    for (genvar k = 0; k < 6; k++) begin : g_src
        assign tick[k] = rateTick(srcCfg[k][`EXT_CFG_RATE_HI:`EXT_CFG_RATE_LO], slowMode,
                                  q.preScale, lfTick);

        noise_canceller #(
            .STABLE_TICKS(STABLE_TICKS)
        ) u_filt (
            .clk(core_clk),
            .resetn(resetn),
            .run(q.gate[k]),
            .tick(tick[k]),
            .din(extIrqPin[k]),
            .dout(filtered[k])
        );

        trigger_detect u_det (
            .clk(core_clk),
            .resetn(resetn),
            .run(q.gate[k]),
            .filtered(filtered[k]),
            .trig(srcCfg[k][`EXT_CFG_TRIG_HI:`EXT_CFG_TRIG_LO]),
            .reqPulse(irqRequest[k]),
            .level(srcLevel[k])
        );
    end

    // ------------------------------------------------------------------------
    // Bus slave, registers and prescalers.
    // ------------------------------------------------------------------------

    // One wait state: the answer is prepared in the first access cycle and
    // the write lands on the edge that samples pready, so a held request
    // is never applied twice.
    always_comb begin
        d = q;
        d.preScale = q.preScale + 4'h1;
        d.lfPrev = lowFreqClk;
        if (lowFreqClk && !q.lfPrev) begin
            d.lfCnt = q.lfCnt + 2'h1;
        end
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        if (access && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = (sel == REG_NONE);
            unique case (sel)
                REG_GATE: d.prdata = {26'h000_0000, q.gate};
                REG_CFG1: d.prdata = {27'h000_0000, srcLevel[1], q.cfg1};
                REG_CFG2: d.prdata = {27'h000_0000, srcLevel[2], q.cfg2};
                REG_NONE: d.prdata = 32'h0000_0000;
            endcase
        end
        if (wrAccept) begin
            unique case (sel)
                REG_GATE: d.gate = pwdata[5:0];
                REG_CFG1: begin
                    if (q.gate[1]) begin
                        d.cfg1 = pwdata[3:0];
                    end
                end
                REG_CFG2: begin
                    if (q.gate[2]) begin
                        d.cfg2 = pwdata[3:0];
                    end
                end
                REG_NONE: d.cfg1 = q.cfg1;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign prdata = q.prdata;

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_gated_write_lost: assert property (
        (wrAccept && sel == REG_CFG1 && !q.gate[1]) |=> (q.cfg1 == $past(q.cfg1)))
        else $error("config write took effect while source ungated");

    chk_gate_upper_zero: assert property (
        (pready && sel == REG_GATE && !pwrite) |-> (prdata[7:6] == 2'b00))
        else $error("gate register upper bits not zero");

    chk_cfg_upper_zero: assert property (
        (pready && (sel == REG_CFG1 || sel == REG_CFG2)) |-> (prdata[7:5] == 3'b000))
        else $error("config register bits 7 to 5 not zero");

    chk_rise_gives_high: assert property (
        (irqRequest[1] && $past(q.cfg1[3:2]) == `EXT_TRIG_RISE) |-> srcLevel[1])
        else $error("rising trigger captured low level");

    chk_fall_gives_low: assert property (
        (irqRequest[2] && $past(q.cfg2[3:2]) == `EXT_TRIG_FALL) |-> !srcLevel[2])
        else $error("falling trigger captured high level");

    chk_reserved_silent: assert property (
        ($past(q.cfg1[3:2]) == 2'b11) |-> !irqRequest[1])
        else $error("reserved trigger code raised a request");

    chk_from_filter: assert property (
        irqRequest[1] |-> ($past(filtered[1], 2) != $past(filtered[1])))
        else $error("request without a filtered transition");

    chk_level_capture: assert property (
        irqRequest[2] |-> (srcLevel[2] == $past(filtered[2])))
        else $error("level flag not refreshed at request");

    chk_single_pulse: assert property (
        irqRequest[1] |=> !irqRequest[1])
        else $error("request longer than one cycle");

    chk_rate_div4: assert property (
        (!slowMode && q.cfg1[1:0] == `EXT_RATE_DIV4 && tick[1]) |-> (q.preScale[1:0] == 2'h3))
        else $error("divide-by-4 tick at wrong prescale phase");

    chk_slow_rate: assert property (
        (slowMode && tick[2]) |-> lfTick)
        else $error("slow-mode tick not from quarter low clock");

    chk_src0_fixed: assert property (
        irqRequest[0] |-> !srcLevel[0])
        else $error("source 0 request not on falling edge");

    // Requests and canceller moves follow the gate as it stood one edge earlier,
    // because both are registered from the gate of the previous cycle.
    chk_ungated_quiet: assert property (
        (irqRequest & ~$past(q.gate)) == 6'h00)
        else $error("ungated source raised a request");

    chk_ungated_frozen: assert property (
        !$past(q.gate[2]) |-> $stable(filtered[2]))
        else $error("ungated canceller output moved");

    chk_cfg2_gated: assert property (
        (wrAccept && sel == REG_CFG2 && !q.gate[2]) |=> (q.cfg2 == $past(q.cfg2)))
        else $error("config 2 write took effect while source ungated");

    chk_rate_full: assert property (
        (!slowMode && q.cfg1[1:0] == `EXT_RATE_DIV1) |-> tick[1])
        else $error("full-rate source missed a tick");

    chk_rate_div8: assert property (
        (!slowMode && q.cfg1[1:0] == `EXT_RATE_DIV8 && tick[1]) |-> (q.preScale[2:0] == 3'h7))
        else $error("divide-by-8 tick at wrong prescale phase");

    chk_rate_div16: assert property (
        (!slowMode && q.cfg1[1:0] == `EXT_RATE_DIV16 && tick[1]) |-> (q.preScale == 4'hf))
        else $error("divide-by-16 tick at wrong prescale phase");

    chk_slow_no_rate: assert property (
        (slowMode && !lfTick) |-> (tick == 6'h00))
        else $error("slow-mode tick outside the quarter low clock");

    chk_level_src1: assert property (
        irqRequest[1] |-> (srcLevel[1] == $past(filtered[1])))
        else $error("source 1 level flag not taken at request");

    chk_level_hold: assert property (
        !irqRequest[1] |-> $stable(srcLevel[1]))
        else $error("level flag moved without a request");

    chk_src3_fixed: assert property (
        irqRequest[3] |-> srcLevel[3])
        else $error("source 3 request not on rising edge");

    chk_src5_fixed: assert property (
        irqRequest[5] |-> !srcLevel[5])
        else $error("source 5 request not on falling edge");

    chk_pulse_all: assert property (
        (irqRequest & $past(irqRequest)) == 6'h00)
        else $error("a request lasted longer than one cycle");

    cov_rise_req: cover property (irqRequest[1] && q.cfg1[3:2] == `EXT_TRIG_RISE);
    cov_both_req: cover property (irqRequest[2] && q.cfg2[3:2] == `EXT_TRIG_BOTH);
    cov_slow_req: cover property (slowMode && irqRequest[1]);
    cov_bad_addr: cover property (pready && pslverr);

endmodule
`default_nettype wire

// ### verification/ext_pin_model.sv
// Board-side model of the external interrupt pins and the low-frequency clock.
`timescale 1ns/100ps
`default_nettype none

module ext_pin_model #(
    parameter int LF_HALF = 4
) (
    input wire logic core_clk,
    output var logic [5:0] extIrqPin,
    output var logic lowFreqClk
);
    int lfCnt;

    // Every pin starts low, which the fixed falling-edge sources treat as idle.
    initial begin
        extIrqPin = 6'h00;
        lowFreqClk = 1'b0;
        lfCnt = 0;
    end

    // The low-frequency clock runs free, as a watch crystal does in any mode.
    always @(posedge core_clk) begin
        lfCnt <= (lfCnt == LF_HALF - 1) ? 0 : lfCnt + 1;
        if (lfCnt == LF_HALF - 1) begin
            lowFreqClk <= ~lowFreqClk;
        end
    end

    // One pin goes high for len cycles and drops again; a short len models a glitch.
    task automatic pulse(input int src, input int len);
        @(posedge core_clk);
        extIrqPin <= extIrqPin | (6'h01 << src);
        repeat (len) @(posedge core_clk);
        extIrqPin <= extIrqPin & ~(6'h01 << src);
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the external interrupt front end.
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defines.svh"

module tb;
    localparam logic [13:0] GATE_A = {`EXT_GATE_IDX, 2'b00};
    localparam logic [13:0] CFG1_A = {`EXT_CFG1_IDX, 2'b00};
    localparam logic [13:0] CFG2_A = {`EXT_CFG2_IDX, 2'b00};
    localparam int LIMIT = 20000;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, slowMode, lowFreqClk, err;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] extIrqPin, irqRequest, prevReq;
    int n_errors, checks_done, cycles, hiCnt, riseSum, d;
    int reqCnt [6];
    int expN [4] = '{1, 1, 2, 0};
    int fixedSrc [4] = '{0, 3, 4, 5};

    ext_interrupt_filter_edge ext_interrupt_filter_edge_inst (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .extIrqPin(extIrqPin),
        .slowMode(slowMode), .lowFreqClk(lowFreqClk), .irqRequest(irqRequest)
    );
    ext_pin_model ext_pin_model_inst (
        .core_clk(core_clk), .extIrqPin(extIrqPin), .lowFreqClk(lowFreqClk)
    );

    // ------------------------------------------------------------------
    // Clock, request monitor and hang guard.
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Rising edges and high cycles are counted apart, so a stretched pulse shows up.
    always @(posedge core_clk) begin
        cycles++;
        for (int i = 0; i < 6; i++) begin
            if (irqRequest[i] === 1'b1 && prevReq[i] !== 1'b1) begin
                reqCnt[i]++;
                riseSum++;
            end
            if (irqRequest[i] === 1'b1) begin
                hiCnt++;
            end
        end
        prevReq = irqRequest;
        if (cycles == LIMIT) begin
            n_errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [13:0] addr, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [13:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(rd, exp);
    endtask

    // Pulses a pin and compares the number of requests that source raised.
    task automatic pulse_cnt(input int src, input int len, input int gap, input int n);
        int base;
        repeat (4) @(posedge core_clk);
        base = reqCnt[src];
        ext_pin_model_inst.pulse(src, len);
        repeat (gap) @(posedge core_clk);
        check(32'(reqCnt[src] - base), 32'(n));
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        slowMode = 1'b0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        rd_chk(GATE_A, 32'h0000_0000);
        rd_chk(CFG1_A, 32'h0000_0000);
        rd_chk(CFG2_A, 32'h0000_0000);
        apb(1'b0, 14'h0004, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        check(rd, 32'h0000_0000);
        // A config write before its gate is set must be lost.
        apb(1'b1, CFG1_A, 32'h0000_0004);
        rd_chk(CFG1_A, 32'h0000_0000);
        apb(1'b1, GATE_A, 32'h0000_00ff);
        rd_chk(GATE_A, 32'h0000_003f);
        apb(1'b1, CFG1_A, 32'h0000_00ff);
        rd_chk(CFG1_A, 32'h0000_000f);
        // Every trigger code once, with the level flag after each request.
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, CFG1_A, 32'(c << 2));
            pulse_cnt(1, 10, 12, expN[c]);
            rd_chk(CFG1_A, 32'((c == 0 ? 16 : 0) | (c << 2)));
        end
        // Each sampling rate rejects a pulse under two ticks and passes a longer one.
        for (int r = 0; r < 4; r++) begin
            d = (r == 0) ? 1 : (2 << r);
            apb(1'b1, CFG1_A, 32'(r));
            pulse_cnt(1, (d == 1) ? 1 : d - 1, 3 * d + 4, 0);
            pulse_cnt(1, 3 * d, 3 * d + 4, 1);
        end
        // Slow mode samples at a quarter of the low clock whatever the rate field holds.
        apb(1'b1, CFG1_A, 32'h0000_0000);
        slowMode <= 1'b1;
        repeat (96) @(posedge core_clk);
        pulse_cnt(1, 20, 80, 0);
        pulse_cnt(1, 100, 100, 1);
        slowMode <= 1'b0;
        repeat (8) @(posedge core_clk);
        // An ungated source raises nothing and keeps its old configuration.
        apb(1'b1, GATE_A, 32'h0000_003d);
        pulse_cnt(1, 10, 12, 0);
        apb(1'b1, CFG1_A, 32'h0000_0008);
        rd_chk(CFG1_A, 32'h0000_0010);
        apb(1'b1, GATE_A, 32'h0000_003f);
        for (int c = 0; c < 3; c++) begin
            apb(1'b1, CFG2_A, 32'(c << 2));
            pulse_cnt(2, 10, 12, expN[c]);
            rd_chk(CFG2_A, 32'((c == 0 ? 16 : 0) | (c << 2)));
        end
        foreach (fixedSrc[i]) begin
            pulse_cnt(fixedSrc[i], 10, 12, 1);
        end
        check(32'(hiCnt), 32'(riseSum));
        print_verdict();
    end
endmodule
`default_nettype wire
